// file: pkg/oaa_pkg.sv
// oaa_pkg: constants, commands and carriers of the operand addressing datapath
// assumes one core clock and a sequencer that hands over decoded commands
`default_nettype none
package oaa_pkg;
   localparam int unsigned RAM_DEPTH = 256;
   // special function register addresses held inside the datapath
   localparam logic [7:0] SFR_SP    = 8'h81;
   localparam logic [7:0] SFR_DPL   = 8'h82;
   localparam logic [7:0] SFR_DPH   = 8'h83;
   localparam logic [7:0] SFR_PSW   = 8'hD0;
   localparam logic [7:0] SFR_ACC   = 8'hE0;
   localparam logic [7:0] SFR_B     = 8'hF0;
   // status word bit positions
   localparam int unsigned BIT_CY    = 7;
   localparam int unsigned BIT_AC    = 6;
   localparam int unsigned BIT_RS_HI = 4;
   localparam int unsigned BIT_RS_LO = 3;
   localparam int unsigned BIT_OV    = 2;
   localparam int unsigned BIT_PAR   = 0;
   // values after reset, and the largest decimal digit
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [7:0]  RST_SP    = 8'h07;
   localparam logic [15:0] RST_DATA_POINTER  = 16'h0000;
   localparam logic [3:0]  BCD_MAX   = 4'h9;
   typedef enum logic [19:0] {
      OP_ADD        = 20'h0_0001,
      OP_ADD_CARRY  = 20'h0_0002,
      OP_SUB_BORROW = 20'h0_0004,
      OP_INC        = 20'h0_0008,
      OP_DEC        = 20'h0_0010,
      OP_INC_PTR    = 20'h0_0020,
      OP_MUL        = 20'h0_0040,
      OP_DIV        = 20'h0_0080,
      OP_DEC_ADJ    = 20'h0_0100,
      OP_AND        = 20'h0_0200,
      OP_OR         = 20'h0_0400,
      OP_XOR        = 20'h0_0800,
      OP_CLEAR      = 20'h0_1000,
      OP_INVERT     = 20'h0_2000,
      OP_ROL        = 20'h0_4000,
      OP_ROR        = 20'h0_8000,
      OP_ROL_C      = 20'h1_0000,
      OP_ROR_C      = 20'h2_0000,
      OP_SWAP       = 20'h4_0000,
      OP_MOVE_CODE  = 20'h8_0000
   } oaa_op_t;
   typedef enum logic [5:0] {
      MODE_DIRECT    = 6'h01,
      MODE_INDIRECT  = 6'h02,
      MODE_REGISTER  = 6'h04,
      MODE_IMPLIED   = 6'h08,
      MODE_IMMEDIATE = 6'h10,
      MODE_INDEXED   = 6'h20
   } oaa_mode_t;
   typedef enum logic [3:0] {
      PTR_REG_ZERO = 4'h1,
      PTR_REG_ONE  = 4'h2,
      PTR_STACK    = 4'h4,
      PTR_DATA     = 4'h8
   } oaa_ptr_t;
   typedef enum logic [5:0] {
      LOC_NONE = 6'h01,
      LOC_RAM  = 6'h02,
      LOC_SFR  = 6'h04,
      LOC_XRAM = 6'h08,
      LOC_IMM  = 6'h10,
      LOC_CODE = 6'h20
   } oaa_loc_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_PTR  = 3'h2,
      ST_EXEC = 3'h4
   } oaa_state_t;
   typedef struct packed {
      oaa_op_t    op;
      oaa_mode_t  mode;
      oaa_ptr_t   ptr;
      logic       external;
      logic       to_byte;
      logic       src_imm;
      logic       idx_pc;
      logic [2:0] reg_num;
      logic [7:0] dir_addr;
      logic [7:0] imm;
      logic [15:0] pc;
   } oaa_cmd_t;
   typedef struct packed {
      logic        rd;
      logic [15:0] raddr;
      logic        wr;
      logic [15:0] waddr;
      logic [7:0]  wdata;
   } oaa_bus_t;
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  second_operand;
      logic [7:0]  program_status_word;
      logic [7:0]  stack_pointer;
      logic [15:0] data_pointer;
   } oaa_regs_t;
endpackage
`default_nettype wire

// file: verilog/oaa_ram.sv
// oaa_ram: internal data RAM, one registered read port, one write port
// assumes write and read of one address in one cycle want the new data
`default_nettype none
`timescale 1ns/10ps
module oaa_ram #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 256,
   localparam int unsigned AW   = $clog2(DEPTH)
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_rd_data;

   if (DEPTH < 2 || WIDTH < 1) begin : g_check
      $error("oaa_ram: depth or width too small");
   end

   // write-first so a write-back is seen by the very next command
   always_comb begin
      next_rd_data = (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   // contents are not reset, as in the real array
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule
`default_nettype wire

// file: verilog/oaa_alu.sv
// oaa_alu: operand addressing and byte arithmetic/logic datapath
// assumes the sequencer holds a command until taken and that external
// data, sfr and code memories answer a read one cycle after the request
// Contract
// - direct: 8-bit field, RAM or SFR 80h-FFh
// - indirect byte address from pointer registers or stack
// - sixteen-bit indirect address only from data pointer
// - register mode: 3-bit number from opcode
// - bank chosen by status word bits when the command is taken
// - implied register from opcode; immediate from code
// - indexed: code read at base plus accumulator
// - add, add with carry, subtract with borrow
// - increment/decrement in place in RAM or SFR; implied mode steps the accumulator
// - data pointer increments as one sixteen-bit step
// - multiply: high byte second operand, low accumulator
// - divide: quotient accumulator, remainder second operand
// - decimal adjust corrects packed BCD after add
// - bitwise and, or, xor with accumulator
// - and, or, xor into direct byte, accumulator kept
// - plain rotates by one position
// - rotates through carry form nine-bit loop
// - swap exchanges accumulator nibbles
// - arithmetic operand by direct, indirect, register, immediate
// - banks at RAM 0-31, bank and number form address
`default_nettype none
`timescale 1ns/10ps
module oaa_alu import oaa_pkg::*; #(
   parameter int unsigned RAM_WORDS = RAM_DEPTH
) (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire oaa_cmd_t   cmd_in,
   output logic            cmd_done,
   output oaa_regs_t       core_regs,
   output oaa_bus_t        xram_req,
   input  wire logic [7:0] xram_rdata,
   output oaa_bus_t        sfr_req,
   input  wire logic [7:0] sfr_rdata,
   output oaa_bus_t        code_req,
   input  wire logic [7:0] code_rdata
);
   if (RAM_WORDS != RAM_DEPTH) begin : g_check
      $error("oaa_alu: indirect byte addresses need exactly 256 RAM words");
   end

   oaa_state_t  state, next_state;
   oaa_cmd_t    cmd_q, next_cmd;
   oaa_loc_t    loc, next_loc, wr_loc, next_wr_loc;
   logic [15:0] loc_addr, next_addr, wr_addr, next_wr_addr;
   logic [7:0]  wr_data, next_wr_data;
   oaa_regs_t   regs, next_regs;
   logic        next_done;
   logic        launch;
   logic        wr_byte;
   logic        cin;
   logic [7:0]  byte_val, src2, result, ram_rdata;
   logic [8:0]  sum9, adj;
   logic [4:0]  half;
   logic [15:0] prod;
   logic [1:0]  bank;

   assign bank = regs.program_status_word[BIT_RS_HI:BIT_RS_LO];

   // register n of the active bank sits in RAM 0..31
   function automatic logic [15:0] bank_reg(input logic [1:0] b, input logic [2:0] n);
      return {11'h000, b, n};
   endfunction

   always_comb begin
      next_state   = state;
      next_cmd     = cmd_q;
      next_loc     = loc;
      next_addr    = loc_addr;
      next_regs    = regs;
      next_wr_loc  = LOC_NONE;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_done    = 1'b0;
      launch       = 1'b0;
      wr_byte      = 1'b0;
      cin          = 1'b0;
      byte_val     = 8'h00;
      src2         = 8'h00;
      result       = 8'h00;
      sum9         = 9'h000;
      adj          = 9'h000;
      half         = 5'h00;
      prod         = 16'h0000;
      unique case (state)
         ST_IDLE: begin
            if (cmd_valid) begin
               launch     = 1'b1;
               next_cmd   = cmd_in;
               next_state = ST_EXEC;
               unique case (cmd_in.mode)
                  MODE_DIRECT: begin
                     next_loc  = cmd_in.dir_addr[7] ? LOC_SFR : LOC_RAM;
                     next_addr = {8'h00, cmd_in.dir_addr};
                  end
                  MODE_REGISTER: begin
                     next_loc  = LOC_RAM;
                     next_addr = bank_reg(bank, cmd_in.reg_num);
                  end
                  MODE_INDIRECT: begin
                     if (cmd_in.ptr == PTR_DATA) begin
                        next_loc  = LOC_XRAM;
                        next_addr = regs.data_pointer;
                     end else if (cmd_in.ptr == PTR_STACK) begin
                        next_loc  = cmd_in.external ? LOC_XRAM : LOC_RAM;
                        next_addr = {8'h00, regs.stack_pointer};
                     end else begin
                        // first fetch the pointer register itself
                        next_loc   = LOC_RAM;
                        next_addr  = bank_reg(bank, {2'b00, cmd_in.ptr == PTR_REG_ONE});
                        next_state = ST_PTR;
                     end
                  end
                  MODE_IMMEDIATE: begin
                     next_loc = LOC_IMM;
                  end
                  MODE_INDEXED: begin
                     next_loc  = LOC_CODE;
                     next_addr = (cmd_in.idx_pc ? cmd_in.pc : regs.data_pointer)
                                 + {8'h00, regs.acc};
                  end
                  default: begin
                     next_loc = LOC_NONE;
                  end
               endcase
            end
         end
         ST_PTR: begin
            launch     = 1'b1;
            next_loc   = cmd_q.external ? LOC_XRAM : LOC_RAM;
            next_addr  = {8'h00, ram_rdata};
            next_state = ST_EXEC;
         end
         ST_EXEC: begin
            next_state = ST_IDLE;
            next_done  = 1'b1;
            unique case (loc)
               LOC_RAM:  byte_val = ram_rdata;
               LOC_XRAM: byte_val = xram_rdata;
               LOC_IMM:  byte_val = cmd_q.imm;
               LOC_CODE: byte_val = code_rdata;
               LOC_SFR: begin
                  case (loc_addr[7:0])
                     SFR_ACC: byte_val = regs.acc;
                     SFR_B:   byte_val = regs.second_operand;
                     SFR_PSW: byte_val = regs.program_status_word;
                     SFR_SP:  byte_val = regs.stack_pointer;
                     SFR_DPL: byte_val = regs.data_pointer[7:0];
                     SFR_DPH: byte_val = regs.data_pointer[15:8];
                     default: byte_val = sfr_rdata;
                  endcase
               end
               default:  byte_val = 8'h00;
            endcase
            src2 = cmd_q.src_imm ? cmd_q.imm : regs.acc;
            cin  = regs.program_status_word[BIT_CY];
            unique case (cmd_q.op)
               OP_ADD, OP_ADD_CARRY: begin
                  if (cmd_q.op == OP_ADD) cin = 1'b0;
                  sum9 = {1'b0, regs.acc} + {1'b0, byte_val} + {8'h00, cin};
                  half = {1'b0, regs.acc[3:0]} + {1'b0, byte_val[3:0]} + {4'h0, cin};
                  next_regs.acc = sum9[7:0];
                  next_regs.program_status_word[BIT_CY] = sum9[8];
                  next_regs.program_status_word[BIT_AC] = half[4];
                  next_regs.program_status_word[BIT_OV] = (regs.acc[7] == byte_val[7])
                                                          && (sum9[7] != regs.acc[7]);
               end
               OP_SUB_BORROW: begin
                  sum9 = {1'b0, regs.acc} - {1'b0, byte_val} - {8'h00, cin};
                  half = {1'b0, regs.acc[3:0]} - {1'b0, byte_val[3:0]} - {4'h0, cin};
                  next_regs.acc = sum9[7:0];
                  next_regs.program_status_word[BIT_CY] = sum9[8];
                  next_regs.program_status_word[BIT_AC] = half[4];
                  next_regs.program_status_word[BIT_OV] = (regs.acc[7] != byte_val[7])
                                                          && (sum9[7] != regs.acc[7]);
               end
               OP_INC, OP_DEC: begin
                  if (cmd_q.mode == MODE_IMPLIED) begin
                     next_regs.acc = (cmd_q.op == OP_INC) ? regs.acc + 8'h01
                                                          : regs.acc - 8'h01;
                  end else begin
                     result  = (cmd_q.op == OP_INC) ? byte_val + 8'h01 : byte_val - 8'h01;
                     wr_byte = 1'b1;
                  end
               end
               OP_INC_PTR: next_regs.data_pointer = regs.data_pointer + 16'h0001;
               OP_MUL: begin
                  prod = {8'h00, regs.acc} * {8'h00, regs.second_operand};
                  next_regs.second_operand = prod[15:8];
                  next_regs.acc = prod[7:0];
                  next_regs.program_status_word[BIT_CY] = 1'b0;
                  next_regs.program_status_word[BIT_OV] = |prod[15:8];
               end
               OP_DIV: begin
                  // divide by zero keeps both bytes and raises overflow
                  next_regs.program_status_word[BIT_CY] = 1'b0;
                  next_regs.program_status_word[BIT_OV] = regs.second_operand == 8'h00;
                  if (regs.second_operand != 8'h00) begin
                     next_regs.acc = regs.acc / regs.second_operand;
                     next_regs.second_operand = regs.acc % regs.second_operand;
                  end
               end
               OP_DEC_ADJ: begin
                  adj = {1'b0, regs.acc};
                  if (adj[3:0] > BCD_MAX || regs.program_status_word[BIT_AC]) begin
                     adj = adj + 9'h006;
                  end
                  if (adj[7:4] > BCD_MAX || adj[8] || cin) begin
                     adj = adj + 9'h060;
                  end
                  next_regs.acc = adj[7:0];
                  // carry is only ever set here, never cleared
                  next_regs.program_status_word[BIT_CY] = cin | adj[8];
               end
               OP_AND, OP_OR, OP_XOR: begin
                  unique case (cmd_q.op)
                     OP_AND:  result = (cmd_q.to_byte ? src2 : regs.acc) & byte_val;
                     OP_OR:   result = (cmd_q.to_byte ? src2 : regs.acc) | byte_val;
                     default: result = (cmd_q.to_byte ? src2 : regs.acc) ^ byte_val;
                  endcase
                  if (cmd_q.to_byte) begin
                     wr_byte = 1'b1;
                  end else begin
                     next_regs.acc = result;
                  end
               end
               OP_CLEAR:  next_regs.acc = 8'h00;
               OP_INVERT: next_regs.acc = ~regs.acc;
               OP_ROL:    next_regs.acc = {regs.acc[6:0], regs.acc[7]};
               OP_ROR:    next_regs.acc = {regs.acc[0], regs.acc[7:1]};
               OP_ROL_C: begin
                  next_regs.acc = {regs.acc[6:0], cin};
                  next_regs.program_status_word[BIT_CY] = regs.acc[7];
               end
               OP_ROR_C: begin
                  next_regs.acc = {cin, regs.acc[7:1]};
                  next_regs.program_status_word[BIT_CY] = regs.acc[0];
               end
               OP_SWAP:      next_regs.acc = {regs.acc[3:0], regs.acc[7:4]};
               OP_MOVE_CODE: next_regs.acc = byte_val;
               default: begin
                  next_regs = regs;
               end
            endcase
            if (wr_byte) begin
               next_wr_addr = loc_addr;
               next_wr_data = result;
               if (loc == LOC_SFR) begin
                  case (loc_addr[7:0])
                     SFR_ACC: next_regs.acc = result;
                     SFR_B:   next_regs.second_operand = result;
                     SFR_PSW: next_regs.program_status_word = result;
                     SFR_SP:  next_regs.stack_pointer = result;
                     SFR_DPL: next_regs.data_pointer[7:0] = result;
                     SFR_DPH: next_regs.data_pointer[15:8] = result;
                     default: next_wr_loc = LOC_SFR;
                  endcase
               end else if (loc == LOC_RAM) begin
                  next_wr_loc = LOC_RAM;
               end
            end
            next_regs.program_status_word[BIT_PAR] = ^next_regs.acc;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state    <= ST_IDLE;
         cmd_q    <= '0;
         loc      <= LOC_NONE;
         loc_addr <= RST_DATA_POINTER;
         wr_loc   <= LOC_NONE;
         wr_addr  <= RST_DATA_POINTER;
         wr_data  <= RST_BYTE;
         cmd_done <= 1'b0;
         regs     <= '{RST_BYTE, RST_BYTE, RST_BYTE, RST_SP, RST_DATA_POINTER};
      end else begin
         state    <= next_state;
         cmd_q    <= next_cmd;
         loc      <= next_loc;
         loc_addr <= next_addr;
         wr_loc   <= next_wr_loc;
         wr_addr  <= next_wr_addr;
         wr_data  <= next_wr_data;
         cmd_done <= next_done;
         regs     <= next_regs;
      end
   end

   assign cmd_ready = state == ST_IDLE;
   assign core_regs = regs;
   assign xram_req  = '{launch && next_loc == LOC_XRAM, next_addr,
                        1'b0, wr_addr, wr_data};
   assign sfr_req   = '{launch && next_loc == LOC_SFR, next_addr,
                        wr_loc == LOC_SFR, wr_addr, wr_data};
   assign code_req  = '{launch && next_loc == LOC_CODE, next_addr, 1'b0, 16'h0000, 8'h00};

   oaa_ram #(
      .WIDTH (8),
      .DEPTH (RAM_WORDS)
   ) u_ram (
      .clock   (clock),
      .reset_n (reset_n),
      .rd_addr (next_addr[7:0]),
      .rd_data (ram_rdata),
      .wr_en   (wr_loc == LOC_RAM),
      .wr_addr (wr_addr[7:0]),
      .wr_data (wr_data)
   );

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   logic exec, taken;
   assign exec  = state == ST_EXEC;
   assign taken = cmd_valid && cmd_ready;

   reg_bank_a: assert property (taken && cmd_in.mode == MODE_REGISTER |->
      next_addr == {11'h000, bank, cmd_in.reg_num}) else $error("bank register address wrong");
   direct_sfr_a: assert property (taken && cmd_in.mode == MODE_DIRECT && cmd_in.dir_addr[7]
      |=> loc == LOC_SFR && loc_addr[7:0] == $past(cmd_in.dir_addr))
      else $error("direct high address not in sfr space");
   wide_ptr_a: assert property (xram_req.rd && xram_req.raddr[15:8] != 8'h00 |->
      xram_req.raddr == regs.data_pointer) else $error("wide address not from data pointer");
   index_addr_a: assert property (code_req.rd |-> code_req.raddr ==
      (cmd_in.idx_pc ? cmd_in.pc : regs.data_pointer) + {8'h00, regs.acc})
      else $error("indexed code address wrong");
   add_sum_a: assert property (exec && cmd_q.op == OP_ADD |=>
      {regs.program_status_word[BIT_CY], regs.acc} == $past({1'b0, regs.acc} + {1'b0, byte_val}))
      else $error("add result or carry wrong");
   mul_prod_a: assert property (exec && cmd_q.op == OP_MUL |=>
      {regs.second_operand, regs.acc} ==
      $past({8'h00, regs.acc} * {8'h00, regs.second_operand})) else $error("product wrong");
   div_quot_a: assert property (exec && cmd_q.op == OP_DIV && regs.second_operand != 8'h00
      |=> regs.acc == $past(regs.acc / regs.second_operand)
      && regs.second_operand == $past(regs.acc % regs.second_operand))
      else $error("quotient or remainder wrong");
   rot_carry_a: assert property (exec && cmd_q.op == OP_ROL_C |=>
      {regs.program_status_word[BIT_CY], regs.acc} ==
      $past({regs.acc, regs.program_status_word[BIT_CY]})) else $error("carry rotate wrong");
   swap_nib_a: assert property (exec && cmd_q.op == OP_SWAP |=>
      regs.acc == {$past(regs.acc[3:0]), $past(regs.acc[7:4])}) else $error("swap wrong");
   ptr_inc_a: assert property (exec && cmd_q.op == OP_INC_PTR |=>
      regs.data_pointer == $past(regs.data_pointer) + 16'h0001) else $error("pointer step wrong");
   clear_acc_a: assert property (exec && cmd_q.op == OP_CLEAR |=> regs.acc == 8'h00
      && $stable(regs.second_operand) && $stable(regs.data_pointer)) else $error("clear wrong");
   byte_keep_a: assert property (exec && cmd_q.to_byte && loc == LOC_RAM
      |=> $stable(regs.acc) && wr_loc == LOC_RAM) else $error("byte destination disturbed acc");
   done_time_a: assert property (taken |-> ##[2:3] cmd_done) else $error("command not done");

   mul_seen_c:  cover property (exec && cmd_q.op == OP_MUL);
   ptr_path_c:  cover property (state == ST_PTR ##1 exec);
   byte_dest_c: cover property (exec && cmd_q.to_byte && cmd_q.src_imm);
   div_zero_c:  cover property (exec && cmd_q.op == OP_DIV && regs.second_operand == 8'h00);
endmodule
`default_nettype wire

// file: sim/tb_operand_addressing_alu.sv
// self-checking bench for oaa_alu: integer model of accumulator datapath
// assumes memories answer one cycle after a read; sequencer role played here
`timescale 1ns/10ps
`default_nettype none
module tb_operand_addressing_alu;
   import oaa_pkg::*;
   logic clock = 0, reset_n = 0, cmd_valid = 0, cmd_ready, cmd_done;
   oaa_cmd_t cmd_in = '0;
   oaa_regs_t core_regs;
   oaa_bus_t xram_req, sfr_req, code_req;
   logic [7:0] xram_rdata = 8'h5a, sfr_rdata = 8'ha5, code_rdata = 8'h00;
   logic [7:0] ma = 0, mb = 0, mp = 0, im;
   logic [15:0] mdp = 0;
   logic [8:0] r;
   oaa_op_t o;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, i;
   oaa_op_t ops[18] = '{OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW, OP_INC, OP_DEC, OP_INC_PTR,
      OP_MUL, OP_DIV, OP_DEC_ADJ, OP_AND, OP_OR, OP_XOR, OP_CLEAR, OP_INVERT, OP_ROL,
      OP_ROR, OP_ROL_C, OP_ROR_C};
   oaa_alu DUT (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_in(cmd_in), .cmd_done(cmd_done), .core_regs(core_regs),
      .xram_req(xram_req), .xram_rdata(xram_rdata), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .code_req(code_req), .code_rdata(code_rdata));
   always #4 clock = ~clock;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic run(input oaa_op_t op, input oaa_mode_t md, input logic [7:0] v,
                      input logic ip, input logic [7:0] da = 8'h00,
                      input logic dst = 1'b0);
      int k;
      logic ci, h, ov;
      logic [15:0] p;
      @(negedge clock);
      cmd_in = '0;
      cmd_in.op = op;
      cmd_in.mode = md;
      cmd_in.imm = v;
      cmd_in.idx_pc = ip;
      cmd_in.pc = 16'h12f0;
      // da carries the direct address, register number or pointer code
      cmd_in.dir_addr = da;
      cmd_in.reg_num = da[2:0];
      cmd_in.ptr = oaa_ptr_t'(da[3:0]);
      cmd_in.to_byte = dst;
      cmd_in.src_imm = dst;
      code_rdata = 8'($urandom);
      cmd_valid = 1;
      // look at the read requests while they settle, before the taking edge
      #2;
      if (md == MODE_INDEXED) begin
         check(16'(code_req.rd), 16'h0001);
         check(code_req.raddr, (ip ? 16'h12f0 : mdp) + 16'(ma));
      end
      if (md == MODE_DIRECT) check(16'(sfr_req.rd), 16'(da[7]));
      if (md == MODE_INDIRECT && da == 8'h08) check(xram_req.raddr, mdp);
      @(posedge clock);
      ci = (op == OP_ADD) ? 1'b0 : mp[7];
      case (op)
         OP_ADD, OP_ADD_CARRY: begin
            r = ma + v + ci;
            h = (int'(ma[3:0]) + int'(v[3:0]) + ci) > 15;
            ov = ~(ma[7] ^ v[7]) & (ma[7] ^ r[7]);
            {mp[7], mp[6], mp[2], ma} = {r[8], h, ov, r[7:0]};
         end
         OP_SUB_BORROW: begin
            r = {1'b0, ma} - v - ci;
            h = int'(ma[3:0]) < int'(v[3:0]) + ci;
            ov = (ma[7] ^ v[7]) & (ma[7] ^ r[7]);
            {mp[7], mp[6], mp[2], ma} = {r[8], h, ov, r[7:0]};
         end
         OP_MUL: begin
            p = ma * mb;
            {mb, ma, mp[7], mp[2]} = {p, 1'b0, p > 16'h00ff};
         end
         OP_DIV: begin
            ov = mb == 0;
            if (mb != 0) {ma, mb} = {ma / mb, ma % mb};
            {mp[7], mp[2]} = {1'b0, ov};
         end
         OP_DEC_ADJ: begin
            r = {1'b0, ma};
            if (r[3:0] > BCD_MAX || mp[6]) r = r + 9'h006;
            if (r[8]) mp[7] = 1;
            if (r[7:4] > BCD_MAX || mp[7]) r = r + 9'h060;
            if (r[8]) mp[7] = 1;
            ma = r[7:0];
         end
         OP_AND: if (!dst) ma = ma & v; else if (da == SFR_B) mb = mb & v;
         OP_OR: if (!dst) ma = ma | v; else if (da == SFR_B) mb = mb | v;
         OP_XOR: if (!dst) ma = ma ^ v; else if (da == SFR_B) mb = mb ^ v;
         OP_CLEAR: ma = 0;
         OP_INVERT: ma = ~ma;
         OP_ROL: ma = {ma[6:0], ma[7]};
         OP_ROR: ma = {ma[0], ma[7:1]};
         OP_ROL_C: {mp[7], ma} = {ma, mp[7]};
         OP_ROR_C: {ma, mp[7]} = {mp[7], ma};
         OP_SWAP: ma = {ma[3:0], ma[7:4]};
         OP_INC: if (md == MODE_IMPLIED) ma = ma + 1;
         OP_DEC: if (md == MODE_IMPLIED) ma = ma - 1;
         OP_INC_PTR: mdp = mdp + 1;
         default: ma = code_rdata;
      endcase
      mp[0] = ^ma;
      @(negedge clock);
      cmd_valid = 0;
      for (k = 0; k < 6 && cmd_done !== 1'b1; k++) @(negedge clock);
      if (k == 6) check(16'hdead, 16'h0000);
      check(16'(core_regs.acc), 16'(ma));
      check(16'(core_regs.second_operand), 16'(mb));
      check(16'(core_regs.program_status_word), 16'(mp));
      check(core_regs.data_pointer, mdp);
   endtask
   initial begin
      void'($urandom(42));
      repeat (3) @(posedge clock);
      @(negedge clock);
      reset_n = 1;
      check(16'(core_regs.stack_pointer), 16'(RST_SP));
      for (i = 0; i < 256; i++) run(OP_INC_PTR, MODE_IMPLIED, 8'h00, 0);
      run(OP_CLEAR, MODE_IMPLIED, 8'h00, 0);
      run(OP_ADD, MODE_IMMEDIATE, 8'h38, 0);
      run(OP_ADD, MODE_IMMEDIATE, 8'h49, 0);
      run(OP_DEC_ADJ, MODE_IMPLIED, 8'h00, 0);
      run(OP_MOVE_CODE, MODE_INDEXED, 8'h00, 0);
      run(OP_MOVE_CODE, MODE_INDEXED, 8'h00, 1);
      // ram is not reset: and with zero first, then or in the value
      run(OP_AND, MODE_DIRECT, 8'h00, 0, 8'h05, 1);
      run(OP_OR, MODE_DIRECT, 8'h3c, 0, 8'h05, 1);
      run(OP_AND, MODE_DIRECT, 8'h00, 0, 8'h00, 1);
      run(OP_OR, MODE_DIRECT, 8'h05, 0, 8'h00, 1);
      run(OP_ADD, MODE_REGISTER, 8'h3c, 0, 8'h05);
      run(OP_ADD_CARRY, MODE_INDIRECT, 8'h3c, 0, 8'h01);
      run(OP_SUB_BORROW, MODE_INDIRECT, 8'h5a, 0, 8'h08);
      run(OP_XOR, MODE_DIRECT, 8'h3c, 0, 8'h05);
      run(OP_INC, MODE_DIRECT, 8'h00, 0, 8'h05);
      run(OP_ADD, MODE_REGISTER, 8'h3d, 0, 8'h05);
      for (i = 0; i < 400; i++) begin
         im = 8'($urandom);
         o = ops[$urandom % 18];
         run(o, (o == OP_INC || o == OP_DEC) ? MODE_IMPLIED : MODE_IMMEDIATE, im, 0);
         if (i % 7 == 0) run(OP_SWAP, MODE_IMPLIED, im, 0);
         if (i % 3 == 0) run(OP_XOR, MODE_DIRECT, 8'($urandom), 0, SFR_B, 1);
      end
      conclude();
   end
endmodule
`default_nettype wire
